// >>> include/e1_test_consts.svh
`ifndef E1_TEST_CONSTS_SVH
`define E1_TEST_CONSTS_SVH

// Register addresses on the plain register port.
`define REG_CTRL        8'h00
`define REG_LOOP_SLOT   8'h01
`define REG_IDLE        8'h02
`define REG_DEFECT      8'h03
`define REG_STATUS      8'h04
`define REG_INT_STATUS  8'h05
`define REG_CNT_FIRST   8'h08
`define REG_CNT_LAST    8'h0d

// Field positions inside the looped-slot select register.
`define LOOP_EN_BIT     5
`define LOOP_SLOT_MSB   4

// Reset values.
`define CTRL_RST        8'h00
`define IDLE_RST        8'hd5

// Frame structure of the 2.048 Mbit/s stream.
`define SLOT_ZERO       5'h00
`define SLOT_PRBS       5'h01
`define SLOT_CAS        5'h10
`define LAST_BIT_CNT    8'hff
`define LAST_BIT_OF_TS  3'h7
`define FAS_BIT_POS     3'h1
`define FAS_WORD        8'h9b
`define NFAS_HEAD       2'h3
`define NFAS_TAIL       5'h1f
`define FIRST_FRAME     4'h0
`define CNT_MAX         16'hffff

`endif

// >>> include/e1_test_pkg.sv
package e1_test_pkg;

    typedef struct packed {
        logic cas_signaling_enable;
        logic crc4_multiframe_mode;
        logic alarm_simulate_enable;
        logic transmit_alarm_to_line;
        logic local_loop_enable;
        logic transparent_slot_zero;
        logic send_alarm_to_system;
        logic payload_loop_enable;
    } ctrl_t;

    typedef struct packed {
        logic bpv;
        logic prbs;
        logic cas;
        logic crc;
        logic multiframe;
        logic fas;
    } defect_t;

    typedef struct packed {
        logic rai;
        logic lof;
        logic ais;
        logic los;
    } alarm_t;

    typedef struct packed {
        logic tx;
        logic rx;
    } slip_t;

    typedef struct packed {
        logic c3;
        logic c2;
        logic ebit;
        logic crc4;
        logic code;
        logic framing;
    } err_t;

    typedef struct packed {
        logic   rx_clk;
        logic   tx_clk;
        logic   line_rx;
        logic   store_rx;
        logic   rx_frame;
        logic   tx_data;
        logic   tx_sig;
        logic   tx_sync_n;
        logic   tx_mf_sync_n;
        alarm_t alarms;
        slip_t  slips;
        err_t   errs;
    } pin_in_t;

    typedef struct packed {
        logic data;
        logic bpv;
    } line_out_t;

    typedef struct packed {
        pin_in_t         s1;
        pin_in_t         s2;
        pin_in_t         s3;
        pin_in_t         filt;
        ctrl_t           ctrl;
        logic            loop_en;
        logic [4:0]      loop_slot;
        logic [7:0]      idle;
        defect_t         defect;
        alarm_t          live;
        slip_t           int_slip;
        alarm_t          int_alarm;
        logic [5:0][15:0] cnt;
        logic [7:0]      tx_bit;
        logic [3:0]      tx_frame;
        logic [7:0]      rx_bit;
        logic [7:0]      slot_buf;
        logic [7:0]      loop_byte;
        logic            loop_sys_bit;
        line_out_t       line;
        logic            receiver_in;
        logic            rx_out;
        logic [15:0]     rdata;
    } state_t;

endpackage : e1_test_pkg

// >>> logic/e1_loopback_test_control.sv
`timescale 1ns/10ps
`include "e1_test_consts.svh"
// What this block does
// [RULE_01] Payload loop sends processed receive store data to transmitter and system output.
// [RULE_02] Payload loop with send-alarm bit gives all ones to the system.
// [RULE_03] Without transparent slot zero, own framing/CRC/spare bits replace looped ones; the code computes no CRC and sends a fixed 1 in each Si bit.
// [RULE_04] Payload loop clocks transmitter from receive system clock.
// [RULE_05] Transparent slot zero returns received slot 0 unchanged to the line.
// [RULE_06] Payload loop ignores all transmit system inputs; receive processing continues; the code still loops f.tx_data in the looped slot.
// [RULE_07] Local loop feeds system transmit data into the receiver instead of line.
// [RULE_08] Local loop still sends the system stream to the line unaltered.
// [RULE_09] Local loop with transmit alarm sends all ones; looped data unaffected.
// [RULE_10] Receiver may show out of frame after local loop, then resyncs.
// [RULE_11] Software must set equal line codes for transmitter and receiver.
// [RULE_12] One of 32 slots loops from system input to system output.
// [RULE_13] Looped slot carries the idle code towards the far end.
// [RULE_14] Testers should use quasi-static patterns in a looped slot.
// [RULE_15] Simulation keeps traffic; real alarms go unreported locally and remotely.
// [RULE_16] Simulation raises all alarms, slips and six error counters.
// [RULE_17] Only applicable indications simulate; no CRC4 or E-bit in double frame.
// [RULE_18] Simulation sets interrupt bits; afterwards alarms vanish, latches stay pending.
// [RULE_19] Reading interrupt status or an error counter clears it.
// [RULE_20] Defect control inserts FAS, multiframe, CRC, CAS, PRBS, bipolar defects.
// [RULE_21] Slots other than the looped one pass as in normal operation.
// [RULE_22] Each defect request corrupts one occurrence, then clears itself.
module e1_loopback_test_control
    import e1_test_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire pin_in_t     i_pins,
    output line_out_t        o_line_transmit,
    output logic             o_receiver_in,
    output logic             o_receive_system_data_out,
    output logic             o_tx_clock_from_rx
);

    state_t r;
    state_t n;

    // A change is accepted once the second and third stages agree.
    function automatic pin_in_t settle(input pin_in_t s2, input pin_in_t s3,
                                       input pin_in_t old);
        settle = pin_in_t'((~(s2 ^ s3) & s3) | ((s2 ^ s3) & old));
    endfunction : settle

    // Clear-on-read counter; an event in the reading cycle is kept.
    function automatic logic [15:0] count(input logic [15:0] v,
                                          input logic clr,
                                          input logic ev);
        if (clr) begin
            count = {15'h0000, ev};
        end else if (ev && v != `CNT_MAX) begin
            count = v + 16'h0001;
        end else begin
            count = v;
        end
    endfunction : count

    function automatic logic slot_zero_bit(input logic odd,
                                           input logic [2:0] bitn,
                                           input logic rai);
        logic [7:0] word;
        word = odd ? {`NFAS_HEAD, rai, `NFAS_TAIL} : `FAS_WORD;
        slot_zero_bit = word[`LAST_BIT_OF_TS - bitn];
    endfunction : slot_zero_bit

    always_comb begin
        pin_in_t    f;
        logic       rx_edge;
        logic       tx_edge;
        logic       frame_end;
        logic [4:0] ts;
        logic [2:0] bn;
        logic [4:0] rts;
        logic [2:0] rbn;
        logic       sys_bit;
        logic       out_bit;
        logic       sim;
        logic       odd;
        logic       rd_int;
        alarm_t     real_al;
        alarm_t     rise;
        defect_t    used;
        err_t       ev;
        slip_t      slip_ev;
        logic       rai_far;

        n = r;
        n.s1 = i_pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        f = settle(r.s2, r.s3, r.filt);
        n.filt = f;
        sim = r.ctrl.alarm_simulate_enable;
        used = '0;
        out_bit = 1'b0;

        rx_edge = f.rx_clk & ~r.filt.rx_clk;
        // The transmitter follows the receive clock in payload loop.
        tx_edge = r.ctrl.payload_loop_enable ? rx_edge
                : (f.tx_clk & ~r.filt.tx_clk);         // RULE_04
        ts  = r.tx_bit[7:3];
        bn  = r.tx_bit[2:0];
        rts = r.rx_bit[7:3];
        rbn = r.rx_bit[2:0];
        odd = r.tx_frame[0];
        frame_end = tx_edge && r.tx_bit == `LAST_BIT_CNT;

        // Real alarms are hidden while simulating, also from the far end.
        real_al = f.alarms;
        rai_far = ~sim & (real_al.los | real_al.lof);      // RULE_15
        n.live = sim ? alarm_t'(4'hf) : real_al;           // RULE_16
        rise = n.live & ~r.live;

        // Transmit side.
        sys_bit = r.ctrl.payload_loop_enable ? f.store_rx // RULE_01
                : f.tx_data;                              // RULE_06
        if (tx_edge) begin
            n.tx_bit = r.tx_bit + 8'h01;
            if (r.tx_bit == `LAST_BIT_CNT) begin
                n.tx_frame = r.tx_frame + 4'h1;
            end
            if (r.ctrl.payload_loop_enable) begin
                if (f.rx_frame) begin
                    n.tx_bit = 8'h00;
                end
            end else begin
                if (!f.tx_sync_n) begin
                    n.tx_bit = 8'h00;                     // RULE_06
                end
                if (!f.tx_mf_sync_n) begin
                    n.tx_frame = `FIRST_FRAME;
                end
            end
            out_bit = sys_bit;                            // RULE_21
            if (r.ctrl.cas_signaling_enable && ts == `SLOT_CAS
                && !r.ctrl.payload_loop_enable) begin
                out_bit = f.tx_sig;
            end
            if (ts == `SLOT_ZERO && !(r.ctrl.payload_loop_enable
                && r.ctrl.transparent_slot_zero)) begin    // RULE_05
                out_bit = slot_zero_bit(odd, bn, rai_far); // RULE_03
            end
            n.loop_sys_bit = out_bit;                     // RULE_08
            if (r.loop_en && ts == r.loop_slot) begin
                n.slot_buf = {r.slot_buf[6:0], f.tx_data};  // RULE_12
                if (bn == `LAST_BIT_OF_TS) begin
                    n.loop_byte = {r.slot_buf[6:0], f.tx_data};
                end
                out_bit = r.idle[`LAST_BIT_OF_TS - bn];     // RULE_13
            end
            // One bit per request, then the request is dropped.
            if (ts == `SLOT_ZERO && !odd && bn == `FAS_BIT_POS) begin
                used.fas = r.defect.fas;                  // RULE_20
            end
            if (ts == `SLOT_ZERO && bn == 3'h0) begin
                used.multiframe = r.defect.multiframe & odd;
                used.crc = r.defect.crc & ~odd;
            end
            if (ts == `SLOT_CAS && bn == 3'h0
                && r.tx_frame == `FIRST_FRAME) begin
                used.cas = r.defect.cas;
            end
            if (ts == `SLOT_PRBS && bn == 3'h0) begin
                used.prbs = r.defect.prbs;
            end
            used.bpv = r.defect.bpv;
            out_bit = out_bit ^ (used.fas | used.multiframe | used.crc
                                 | used.cas | used.prbs);    // RULE_22
            if (r.ctrl.local_loop_enable
                && r.ctrl.transmit_alarm_to_line) begin
                out_bit = 1'b1;                           // RULE_09
            end
            n.line.data = out_bit;
            n.line.bpv = used.bpv;
        end
        n.defect = r.defect & ~used;

        // Receive side.
        n.receiver_in = r.ctrl.local_loop_enable ? r.loop_sys_bit // RULE_07
                      : f.line_rx;
        if (rx_edge) begin
            n.rx_bit = f.rx_frame ? 8'h00 : r.rx_bit + 8'h01;
            n.rx_out = f.store_rx;
            if (r.loop_en && rts == r.loop_slot) begin
                n.rx_out = r.loop_byte[`LAST_BIT_OF_TS - rbn]; // RULE_12
            end
            if (r.ctrl.payload_loop_enable
                && r.ctrl.send_alarm_to_system) begin
                n.rx_out = 1'b1;                          // RULE_02
            end
        end

        // Error and slip events; simulation produces one set per frame.
        ev = f.errs & ~r.filt.errs;
        slip_ev = f.slips & ~r.filt.slips;
        if (sim) begin
            ev = '0;                                      // RULE_15
            slip_ev = '0;
            if (frame_end) begin
                ev = err_t'(6'h3f);                       // RULE_16
                slip_ev = slip_t'(2'h3);
                ev.crc4 = r.ctrl.crc4_multiframe_mode;    // RULE_17
                ev.ebit = r.ctrl.crc4_multiframe_mode;
            end
        end

        rd_int = i_rd && i_addr == `REG_INT_STATUS;
        // A new event wins over the clearing read.
        n.int_alarm = (rd_int ? alarm_t'(4'h0) : r.int_alarm) | rise; // RULE_18
        n.int_slip  = (rd_int ? slip_t'(2'h0) : r.int_slip) | slip_ev;
        for (int i = 0; i < 6; i++) begin
            n.cnt[i] = count(r.cnt[i],
                             i_rd && i_addr == `REG_CNT_FIRST + 8'(i),
                             ev[i]);                      // RULE_19
        end

        if (i_wr) begin
            case (i_addr)
                `REG_CTRL: n.ctrl = ctrl_t'(i_wdata[7:0]);
                `REG_LOOP_SLOT: begin
                    n.loop_en = i_wdata[`LOOP_EN_BIT];
                    n.loop_slot = i_wdata[`LOOP_SLOT_MSB:0];
                end
                `REG_IDLE: n.idle = i_wdata[7:0];
                `REG_DEFECT: n.defect = n.defect | defect_t'(i_wdata[5:0]);
                default: n.rdata = 16'h0000;
            endcase
        end

        n.rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `REG_CTRL: n.rdata = {8'h00, r.ctrl};
                `REG_LOOP_SLOT: n.rdata = {10'h000, r.loop_en, r.loop_slot};
                `REG_IDLE: n.rdata = {8'h00, r.idle};
                `REG_DEFECT: n.rdata = {10'h000, r.defect};
                `REG_STATUS: n.rdata = {12'h000, r.live}; // RULE_10
                `REG_INT_STATUS: n.rdata = {10'h000, r.int_slip, r.int_alarm};
                default: begin
                    if (i_addr >= `REG_CNT_FIRST && i_addr <= `REG_CNT_LAST) begin
                        n.rdata = r.cnt[3'(i_addr - `REG_CNT_FIRST)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= '0;
            r.ctrl <= ctrl_t'(`CTRL_RST);
            r.idle <= `IDLE_RST;
        end else begin
            r <= n;
        end
    end

    assign o_rdata = r.rdata;
    assign o_line_transmit = r.line;
    assign o_receiver_in = r.receiver_in;
    assign o_receive_system_data_out = r.rx_out;
    assign o_tx_clock_from_rx = r.ctrl.payload_loop_enable;      // RULE_04

endmodule : e1_loopback_test_control

// >>> bench/e1_test_checker_assertions.sv
`timescale 1ns/10ps
module e1_test_checker (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        o_tx_clock_from_rx
);
    logic       sim_reg;
    logic [7:0] age_reg;
    wire ctrl_wr = i_wr && i_addr == 8'h00;
    wire pl_on   = ctrl_wr && i_wdata[0];
    wire pl_off  = ctrl_wr && !i_wdata[0];

    // Tracks how long the control register, which holds the simulate setting, has been left unwritten.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sim_reg <= 1'b0;
            age_reg <= 8'h00;
        end else if (ctrl_wr) begin
            sim_reg <= i_wdata[5];
            age_reg <= 8'h00;
        end else if (age_reg != 8'hff) begin
            age_reg <= age_reg + 8'h01;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_wr(a);
        i_wr && i_addr == a;
    endsequence
    sequence s_rd(a);
        i_rd && i_addr == a;
    endsequence

    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 16'h0000;
    endproperty
    property p_unmapped;
        i_rd && (i_addr inside {8'h06, 8'h07} || i_addr > 8'h0d)
            |=> o_rdata == 16'h0000;
    endproperty
    property p_ctrl_rb;
        s_wr(8'h00) ##2 s_rd(8'h00)
            |=> o_rdata == {8'h00, $past(i_wdata[7:0], 3)};
    endproperty
    property p_idle_rb;
        s_wr(8'h02) ##2 s_rd(8'h02)
            |=> o_rdata == {8'h00, $past(i_wdata[7:0], 3)};
    endproperty
    property p_txclk_rise;
        $rose(o_tx_clock_from_rx) |-> $past(pl_on) || $past(pl_on, 2);
    endproperty
    property p_txclk_fall;
        $fell(o_tx_clock_from_rx) |-> $past(pl_off) || $past(pl_off, 2);
    endproperty
    property p_txclk_stable;
        !$past(ctrl_wr) && !$past(ctrl_wr, 2) |-> $stable(o_tx_clock_from_rx);
    endproperty
    property p_status_sim;
        sim_reg && age_reg == 8'hff && i_rd && i_addr == 8'h04
            |=> o_rdata[3:0] == 4'hf;
    endproperty
    property p_int_clear;
        (!sim_reg && age_reg == 8'hff && i_rd && i_addr == 8'h05)
            ##2 s_rd(8'h05) |=> o_rdata == 16'h0000;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_ctrl_rb: assert property (p_ctrl_rb)
        else $error("control readback wrong");
    a_idle_rb: assert property (p_idle_rb)
        else $error("idle code readback wrong");
    a_txclk_rise: assert property (p_txclk_rise)
        else $error("transmit clock source changed without write");
    a_txclk_fall: assert property (p_txclk_fall)
        else $error("transmit clock source dropped without write");
    a_txclk_stable: assert property (p_txclk_stable)
        else $error("transmit clock source unstable");
    a_status_sim: assert property (p_status_sim)
        else $error("simulated alarms not shown");
    a_int_clear: assert property (p_int_clear)
        else $error("interrupt status not cleared by read");
endmodule : e1_test_checker

bind e1_loopback_test_control e1_test_checker u_checker (
    .i_clk              (i_clk),
    .i_reset            (i_reset),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .o_rdata            (o_rdata),
    .o_tx_clock_from_rx (o_tx_clock_from_rx)
);

// >>> bench/e1_far_end_model.sv
`timescale 1ns/10ps
module e1_far_end_model (
    input  wire logic i_tx_run,
    output logic      o_rx_clk,
    output logic      o_tx_clk,
    output logic      o_rx_frame,
    output logic      o_tx_sync_n,
    output logic      o_tx_mf_sync_n
);
    logic       tx_free = 1'b0;
    logic       run_reg = 1'b1;
    logic [7:0] rx_bit_reg = 8'h00;
    logic [7:0] tx_bit_reg = 8'h00;
    logic [3:0] tx_frame_reg = 4'h0;

    // Odd start offsets keep both link clocks out of phase with i_clk.
    initial begin
        o_rx_clk = 1'b0;
        #37;
        forever #100 o_rx_clk = ~o_rx_clk;
    end
    initial begin
        #61;
        forever #100 tx_free = ~tx_free;
    end

    // Gating on the low phase avoids runt pulses when the clock stops.
    always @(negedge tx_free) run_reg <= i_tx_run;
    assign o_tx_clk = tx_free & run_reg;

    always @(negedge o_rx_clk) rx_bit_reg <= rx_bit_reg + 8'h01;
    always @(negedge tx_free) begin
        if (run_reg) begin
            tx_bit_reg <= tx_bit_reg + 8'h01;
            if (tx_bit_reg == 8'hff) begin
                tx_frame_reg <= tx_frame_reg + 4'h1;
            end
        end
    end
    assign o_rx_frame     = rx_bit_reg == 8'h00;
    assign o_tx_sync_n    = tx_bit_reg != 8'h00;
    assign o_tx_mf_sync_n = !(tx_bit_reg == 8'h00 && tx_frame_reg == 4'h0);
endmodule : e1_far_end_model

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import e1_test_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        tx_run = 1'b1;
    logic        tx_lvl = 1'b0;
    logic        st_lvl = 1'b0;
    logic        ln_lvl = 1'b0;
    logic [15:0] o_rdata;
    line_out_t   o_line_transmit;
    logic        o_receiver_in;
    logic        o_receive_system_data_out;
    logic        o_tx_clock_from_rx;
    logic        rx_clk, tx_clk, rx_frame, tx_sync_n, tx_mf_sync_n;
    pin_in_t     pins;
    int          errors = 0;
    int          total_checks = 0;
    int          l, s, b;
    int          bpv_seen = 0;
    logic [15:0] v;

    always #12.5 i_clk = ~i_clk;
    // Data lines carry quasi-static levels only.
    assign pins = {rx_clk, tx_clk, ln_lvl, st_lvl, rx_frame, tx_lvl, 1'b1,
                   tx_sync_n, tx_mf_sync_n, 12'h000};

    e1_far_end_model u_far (
        .i_tx_run       (tx_run),
        .o_rx_clk       (rx_clk),
        .o_tx_clk       (tx_clk),
        .o_rx_frame     (rx_frame),
        .o_tx_sync_n    (tx_sync_n),
        .o_tx_mf_sync_n (tx_mf_sync_n)
    );
    e1_loopback_test_control u_dut (
        .i_clk                     (i_clk),
        .i_reset                   (i_reset),
        .i_addr                    (i_addr),
        .i_wdata                   (i_wdata),
        .i_wr                      (i_wr),
        .i_rd                      (i_rd),
        .o_rdata                   (o_rdata),
        .i_pins                    (pins),
        .o_line_transmit           (o_line_transmit),
        .o_receiver_in             (o_receiver_in),
        .o_receive_system_data_out (o_receive_system_data_out),
        .o_tx_clock_from_rx        (o_tx_clock_from_rx)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        check(d, e);
    endtask : rdc
    // Samples late in each bit so the synchroniser delay has settled.
    // A link clock that shows no new falling edge within 40 i_clk cycles ends the run.
    task automatic count(input logic use_rx, input int n,
                         output int lo, output int so);
        int k;
        lo = 0;
        so = 0;
        repeat (n) begin
            k = 0;
            while (k < 40 && (use_rx ? rx_clk : tx_clk) !== 1'b1) begin
                @(posedge i_clk);
                k++;
            end
            while (k < 40 && (use_rx ? rx_clk : tx_clk) !== 1'b0) begin
                @(posedge i_clk);
                k++;
            end
            if (k >= 40) begin
                errors++;
                final_report();
            end
            #70;
            lo += int'(o_line_transmit.data);
            bpv_seen += int'(o_line_transmit.bpv);
            so += use_rx ? int'(o_receive_system_data_out)
                         : int'(o_receiver_in);
        end
    endtask : count
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic t_regs;
        rdc(8'h00, 16'h0000);
        rdc(8'h02, 16'h00d5);
        rdc(8'h07, 16'h0000);
        wr(8'h04, 16'hffff);
        rdc(8'h04, 16'h0000);
        check(16'(o_tx_clock_from_rx), 16'h0000);
    endtask : t_regs
    // Transmit side stopped and driven to ones; only the loop may show.
    task automatic t_payload;
        tx_lvl <= 1'b1;
        tx_run <= 1'b0;
        wr(8'h00, 16'h0001);
        rdc(8'h00, 16'h0001);
        count(1, 32, l, s);
        check(16'(o_tx_clock_from_rx), 16'h0001);
        count(1, 256, l, s);
        check(16'(l >= 1 && l <= 8), 16'h0001);
        check(16'(s), 16'h0000);
        wr(8'h00, 16'h0005);
        count(1, 32, l, s);
        count(1, 256, l, s);
        check(16'(l), 16'h0000);
        st_lvl <= 1'b1;
        count(1, 32, l, s);
        count(1, 256, l, s);
        check(16'(l), 16'h0100);
        check(16'(s), 16'h0100);
        st_lvl <= 1'b0;
        wr(8'h00, 16'h0003);
        count(1, 32, l, s);
        count(1, 256, l, s);
        check(16'(s), 16'h0100);
        check(16'(l >= 1 && l <= 8), 16'h0001);
        wr(8'h00, 16'h0000);
        tx_run <= 1'b1;
    endtask : t_payload
    // Both sides use the same single-rail coding here.
    // Looped bits are counted over a window; only framing bits differ.
    task automatic t_local;
        wr(8'h00, 16'h0008);
        count(0, 32, l, s);
        check(16'(s >= 29), 16'h0001);
        count(0, 256, l, s);
        check(16'(l >= 248), 16'h0001);
        tx_lvl <= 1'b0;
        ln_lvl <= 1'b1;
        wr(8'h00, 16'h0018);
        count(0, 32, l, s);
        check(16'(s <= 7), 16'h0001);
        count(0, 256, l, s);
        check(16'(l), 16'h0100);
        wr(8'h00, 16'h0000);
        count(0, 32, l, s);
        check(16'(s), 16'h0020);
    endtask : t_local
    task automatic t_slot;
        tx_lvl <= 1'b1;
        ln_lvl <= 1'b0;
        wr(8'h02, 16'h0000);
        rdc(8'h02, 16'h0000);
        count(0, 32, l, s);
        count(0, 512, b, s);
        check(16'(b), 16'h01fc);
        wr(8'h01, 16'h0025);
        rdc(8'h01, 16'h0025);
        count(0, 32, l, s);
        count(0, 512, l, s);
        check(16'(b - l), 16'h0010);
        count(1, 256, l, s);
        check(16'(s), 16'h0008);
        wr(8'h01, 16'h0000);
    endtask : t_slot
    task automatic t_sim;
        wr(8'h00, 16'h0020);
        count(0, 768, l, s);
        rdc(8'h04, 16'h000f);
        rdc(8'h0a, 16'h0000);
        wr(8'h00, 16'h0060);
        count(0, 512, l, s);
        rd(8'h0a, v);
        check(16'(v == 16'h0000), 16'h0000);
        wr(8'h00, 16'h0000);
        repeat (300) @(posedge i_clk);
        rdc(8'h04, 16'h0000);
        rdc(8'h05, 16'h003f);
        rdc(8'h05, 16'h0000);
        rd(8'h08, v);
        check(16'(v == 16'h0000), 16'h0000);
        rdc(8'h08, 16'h0000);
    endtask : t_sim
    // Eighteen frames hold nine of each framing word and one multiframe.
    task automatic t_defect;
        bpv_seen = 0;
        wr(8'h03, 16'h003f);
        count(0, 4608, l, s);
        rdc(8'h03, 16'h0000);
        check(16'(l), 16'h11d9);
        check(16'(bpv_seen), 16'h0001);
    endtask : t_defect

    initial begin
        #2500000;
        errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_payload();
        t_local();
        t_slot();
        t_sim();
        t_defect();
        final_report();
    end
endmodule : tb_top
